// File: src/icc_top.sv
// Input capture channel with APB register slave
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ps
module icc_top import icc_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ICC_AW-1:0] paddr,
  input wire logic [ICC_DW-1:0] pwdata,
  output logic [ICC_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic capture_input_pin,
  input wire logic [ICC_TW-1:0] first_timer_count,
  input wire logic [ICC_TW-1:0] second_timer_count,
  input wire logic cpu_idle,
  input wire logic cpu_sleep,
  output logic irq
);
  logic rs1_ff;
  logic rst_n;
  icc_ctrl_t ctrl_ff;
  logic ovf_ff;
  logic [1:0] ev_cnt_ff;
  logic [ICC_IRQ_W-1:0] stat_ff;
  logic [ICC_IRQ_W-1:0] en_ff;
  logic [ICC_DW-1:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic irq_ff;

  // Reset release through two flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rs1_ff <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1_ff <= 1'b1;
      rst_n <= rs1_ff;
    end
  end

  // Bus decode: answer one cycle into the access phase
  wire acc = psel && penable && !pready_ff;
  wire done = psel && penable && pready_ff;
  wire hit_ctrl = (paddr == ICC_OFF_CTRL);
  wire hit_buf = (paddr == ICC_OFF_BUF);
  wire hit_stat = (paddr == ICC_OFF_STAT);
  wire hit_clr = (paddr == ICC_OFF_CLR);
  wire hit_en = (paddr == ICC_OFF_EN);
  wire mapped = hit_ctrl || hit_buf || hit_stat || hit_clr || hit_en;
  wire wr_ctrl = done && pwrite && hit_ctrl;
  wire wr_clr = done && pwrite && hit_clr;
  wire wr_en = done && pwrite && hit_en;
  wire rd_buf = done && !pwrite && hit_buf;

  // Capture path
  wire lowpwr = cpu_idle || cpu_sleep;
  wire halted = (ctrl_ff.idle_halt && cpu_idle) || cpu_sleep; // [R1]
  wire run = !halted;
  wire mode_chg = wr_ctrl && (pwdata[ICC_B_MODE +: 3] != ctrl_ff.mode);
  logic cap_evt;
  logic wake_evt;
  icc_fifo_st_t fst;
  logic [ICC_TW-1:0] head;
  wire [ICC_TW-1:0] sample = ctrl_ff.tsel ? first_timer_count : second_timer_count; // [R2]
  wire push = cap_evt;
  wire ovf_evt = cap_evt && fst.full; // [R17]

  icc_edge u_edge (
    .clk(clk),
    .rst_n(rst_n),
    .pin(capture_input_pin),
    .mode(ctrl_ff.mode),
    .run(run),
    .lowpwr(lowpwr),
    .restart(mode_chg),
    .cap_evt(cap_evt),
    .wake_evt(wake_evt)
  );

  icc_fifo u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .push(push),
    .wdata(sample),
    .pop(rd_buf),
    .rdata(head),
    .st(fst)
  );

  // Interrupt interval: mode 001 fires on every capture stored in the buffer
  wire stored = cap_evt && !fst.full;
  wire every = (ctrl_ff.mode == ICC_M_EDGE); // [R8]
  wire cnt_hit = every || (ev_cnt_ff == ctrl_ff.cpi); // [R3]
  wire int_evt = stored && cnt_hit; // [R18]
  logic [1:0] nxt_ev_cnt;
  assign nxt_ev_cnt = (mode_chg || (wr_ctrl && pwdata[ICC_B_CPI +: 2] != ctrl_ff.cpi)) ? 2'h0
                    : int_evt ? 2'h0
                    : stored ? ev_cnt_ff + 2'h1
                    : ev_cnt_ff; // [R18]

  // Overflow clears only once the buffer is empty; a new overflow wins
  logic nxt_ovf;
  assign nxt_ovf = ovf_evt || (ovf_ff && !fst.empty); // [R17] [R4]

  logic [ICC_IRQ_W-1:0] ev_vec;
  assign ev_vec[ICC_I_CAP] = int_evt;
  assign ev_vec[ICC_I_OVF] = ovf_evt;
  assign ev_vec[ICC_I_WAKE] = wake_evt;
  logic [ICC_IRQ_W-1:0] nxt_stat;
  assign nxt_stat = ev_vec | (stat_ff & ~(wr_clr ? pwdata[ICC_IRQ_W-1:0] : '0));

  // Read mux
  wire [15:0] ctrl_word = icc_ctrl_word(ctrl_ff, ovf_ff, !fst.empty); // [R14] [R5]
  logic [ICC_DW-1:0] rd_mux;
  assign rd_mux = hit_ctrl ? {16'h0000, ctrl_word}
                : hit_buf ? {16'h0000, fst.empty ? 16'h0000 : head}
                : hit_stat ? {29'h0, stat_ff}
                : hit_en ? {29'h0, en_ff}
                : 32'h0000_0000;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else begin
      pready_ff <= acc;
      pslverr_ff <= acc && !mapped;
      if (acc) prdata_ff <= pwrite ? '0 : rd_mux;
    end
  end

  // Only implemented control bits are writable; flags are hardware owned
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= ICC_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_ff.idle_halt <= pwdata[ICC_B_IDLE]; // [R1]
      ctrl_ff.tsel <= pwdata[ICC_B_TSEL]; // [R2]
      ctrl_ff.cpi <= pwdata[ICC_B_CPI +: 2]; // [R3]
      ctrl_ff.mode <= pwdata[ICC_B_MODE +: 3];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_ff <= 1'b0;
      ev_cnt_ff <= 2'h0;
      stat_ff <= '0;
      en_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      ovf_ff <= nxt_ovf;
      ev_cnt_ff <= nxt_ev_cnt;
      stat_ff <= nxt_stat;
      if (wr_en) en_ff <= pwdata[ICC_IRQ_W-1:0];
      irq_ff <= |(nxt_stat & (wr_en ? pwdata[ICC_IRQ_W-1:0] : en_ff));
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq = irq_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_full_capture;
    fst.full && cap_evt;
  endsequence

  sequence s_ovf_held;
    ovf_ff [*1];
  endsequence

  a_reserved_zero: assert property (ctrl_word[15:14] == 2'h0 && ctrl_word[12:8] == 5'h00) // [R14]
    else $error("unimplemented control bits read nonzero");
  a_bne_flag: assert property (ctrl_word[ICC_B_BNE] == !fst.empty) // [R5]
    else $error("buffer flag disagrees with buffer");
  a_ovf_set: assert property (s_full_capture |=> s_ovf_held ##0 ctrl_word[ICC_B_OVF]) // [R17]
    else $error("overflow not flagged on capture into full buffer");
  a_ovf_clear: assert property (fst.empty |=> !ovf_ff) // [R17]
    else $error("overflow survived an empty buffer");
  a_ovf_ro: assert property (wr_ctrl && !ovf_evt && fst.empty |=> !ovf_ff) // [R4]
    else $error("software write changed overflow flag");
  a_mode_off: assert property (ctrl_ff.mode == ICC_M_OFF || ctrl_ff.mode == ICC_M_UNUSED
    |-> !cap_evt && !wake_evt) // [R6] [R12]
    else $error("disabled channel produced an event");
  a_idle_halt: assert property (ctrl_ff.idle_halt && cpu_idle |-> !cap_evt) // [R1]
    else $error("capture while halted in idle");
  a_idle_run: assert property (!ctrl_ff.idle_halt && cpu_idle && !cpu_sleep |-> run) // [R1]
    else $error("channel halted in idle with halt bit clear");
  a_cap_value: assert property (fst.empty && cap_evt |=> head == $past(sample)) // [R15] [R2]
    else $error("stored value is not the selected timer count");
  a_every_int: assert property (stored && every |=> stat_ff[ICC_I_CAP]) // [R8]
    else $error("every-edge capture did not interrupt");
  a_int_interval: assert property (int_evt && !every |-> ev_cnt_ff == ctrl_ff.cpi) // [R3] [R18]
    else $error("interrupt off the chosen interval");
  a_no_early_int: assert property (stored && !every && ev_cnt_ff != ctrl_ff.cpi
    |-> !int_evt) // [R18]
    else $error("interrupt before interval reached");
  a_irq_level: assert property (irq_ff == $past(|(nxt_stat & (wr_en ? pwdata[ICC_IRQ_W-1:0] : en_ff))))
    else $error("interrupt output does not follow enabled status");

  // Register bus handshake
  sequence s_bus_access;
    acc;
  endsequence

  sequence s_bus_reply;
    pready_ff;
  endsequence

  a_ready_follows: assert property (s_bus_access |=> s_bus_reply)
    else $error("access phase not answered next cycle");

  a_ready_pulse: assert property (s_bus_reply |=> !pready_ff)
    else $error("ready held longer than one cycle");

  a_err_unmapped: assert property (acc && !mapped |=> pslverr_ff)
    else $error("unmapped access not flagged");

  a_err_with_ready: assert property (pslverr_ff |-> pready_ff)
    else $error("error flag without ready");

  a_err_mapped: assert property (acc && mapped |=> !pslverr_ff)
    else $error("mapped access flagged as error");

  a_wr_data_zero: assert property (acc && pwrite |=> prdata_ff == '0)
    else $error("write returned nonzero read data");

  a_unmapped_zero: assert property (acc && !mapped |=> prdata_ff == '0)
    else $error("unmapped read returned data");

  a_ctrl_read: assert property (acc && !pwrite && hit_ctrl
    |=> prdata_ff == {16'h0000, $past(ctrl_word)}) // [R14]
    else $error("control read data wrong");

  // Control register ownership
  a_ctrl_hold: assert property (!wr_ctrl |=> $stable(ctrl_ff))
    else $error("control changed without a write");

  a_mode_write: assert property (wr_ctrl |=> ctrl_ff.mode == $past(pwdata[ICC_B_MODE +: 3])) // [R6]
    else $error("mode field not written");

  a_tsel_write: assert property (wr_ctrl |=> ctrl_ff.tsel == $past(pwdata[ICC_B_TSEL])) // [R2]
    else $error("timebase select not written");

  a_halt_write: assert property (wr_ctrl |=> ctrl_ff.idle_halt == $past(pwdata[ICC_B_IDLE])) // [R1]
    else $error("idle halt bit not written");

  a_cpi_write: assert property (wr_ctrl |=> ctrl_ff.cpi == $past(pwdata[ICC_B_CPI +: 2])) // [R3]
    else $error("interval field not written");

  // Capture path
  a_sample_sel: assert property (sample == (ctrl_ff.tsel ? first_timer_count
    : second_timer_count)) // [R2]
    else $error("wrong timer feeds the capture");

  a_sleep_quiet: assert property (cpu_sleep |-> !cap_evt)
    else $error("capture while asleep");

  a_wake_no_store: assert property (ctrl_ff.mode == ICC_M_WAKE |-> !push) // [R13]
    else $error("wake mode stored a value");

  a_bne_after_cap: assert property (stored |=> !fst.empty) // [R5]
    else $error("stored capture left buffer empty");

  a_cnt_bound: assert property (ev_cnt_ff <= ctrl_ff.cpi) // [R18]
    else $error("interval counter past its limit");

  // Status and interrupt
  a_wake_status: assert property (wake_evt |=> stat_ff[ICC_I_WAKE]) // [R13]
    else $error("wake edge not recorded");

  a_ovf_status: assert property (ovf_evt |=> stat_ff[ICC_I_OVF]) // [R17]
    else $error("overflow event not recorded");

  a_stat_sticky: assert property (stat_ff[ICC_I_CAP] && !wr_clr |=> stat_ff[ICC_I_CAP])
    else $error("capture status dropped without a clear");

  a_stat_clear: assert property (wr_clr && pwdata[ICC_I_CAP] && !int_evt
    |=> !stat_ff[ICC_I_CAP])
    else $error("capture status not cleared");

  a_en_write: assert property (wr_en |=> en_ff == $past(pwdata[ICC_IRQ_W-1:0]))
    else $error("enable register not written");

  a_irq_quiet: assert property (stat_ff == '0 && ev_vec == '0 |=> !irq_ff)
    else $error("interrupt without status");

  a_irq_masked: assert property (en_ff == '0 && !wr_en |=> !irq_ff)
    else $error("interrupt while all sources masked");
endmodule // icc_top

// File: include/icc_pkg.sv
// Constants, types and helpers for the input capture channel
// Function
// R1: Idle-halt bit 13 set stops the channel during CPU idle; clear keeps it running.
// R2: Timebase bit 7 one samples the first timer, zero samples the second.
// R3: Field bits 6-5 picks interrupt every first, second, third or fourth capture.
// R4: Read-only overflow flag at bit 4 shows whether an overflow occurred.
// R5: Read-only bit 3 is one while the capture buffer holds unread values.
// R6: Mode 000 switches the channel off.
// R7: Mode 001 captures on every rising and every falling edge.
// R8: In mode 001 interrupts ignore the captures-per-interrupt field.
// R9: Mode 011 captures rising edges; mode 010 captures falling edges.
// R10: Mode 100 captures only on every fourth rising edge.
// R11: Mode 101 captures only on every sixteenth rising edge.
// R12: Mode 110 is unused and behaves as disabled.
// R13: Mode 111 gives only a rising-edge interrupt during sleep or idle.
// R14: Control bits 15-14 and 12-8 always read zero.
// R15: Each capture stores the full 16-bit selected timer count.
// R16: Captures go into a four-deep FIFO read out in capture order.
// R17: Capture into a full buffer sets overflow; emptying the buffer clears it.
// R18: Count captures since last interrupt; interrupt when interval reached.
package icc_pkg;
  localparam int ICC_AW = 8;
  localparam int ICC_DW = 32;
  localparam int ICC_TW = 16;
  localparam int ICC_DEPTH = 4;
  localparam int ICC_PW = 2;
  localparam int ICC_IRQ_W = 3;

  localparam logic [7:0] ICC_OFF_CTRL = 8'h00;
  localparam logic [7:0] ICC_OFF_BUF = 8'h04;
  localparam logic [7:0] ICC_OFF_STAT = 8'h08;
  localparam logic [7:0] ICC_OFF_CLR = 8'h0c;
  localparam logic [7:0] ICC_OFF_EN = 8'h10;

  localparam int ICC_B_IDLE = 13;
  localparam int ICC_B_TSEL = 7;
  localparam int ICC_B_CPI = 5;
  localparam int ICC_B_OVF = 4;
  localparam int ICC_B_BNE = 3;
  localparam int ICC_B_MODE = 0;

  localparam logic [2:0] ICC_M_OFF = 3'h0;
  localparam logic [2:0] ICC_M_EDGE = 3'h1;
  localparam logic [2:0] ICC_M_FALL = 3'h2;
  localparam logic [2:0] ICC_M_RISE = 3'h3;
  localparam logic [2:0] ICC_M_PRE4 = 3'h4;
  localparam logic [2:0] ICC_M_PRE16 = 3'h5;
  localparam logic [2:0] ICC_M_UNUSED = 3'h6;
  localparam logic [2:0] ICC_M_WAKE = 3'h7;

  localparam logic [3:0] ICC_PRE4_LAST = 4'h3;
  localparam logic [3:0] ICC_PRE16_LAST = 4'hf;

  localparam int ICC_I_CAP = 0;
  localparam int ICC_I_OVF = 1;
  localparam int ICC_I_WAKE = 2;

  typedef struct packed {
    logic idle_halt;
    logic tsel;
    logic [1:0] cpi;
    logic [2:0] mode;
  } icc_ctrl_t;

  localparam icc_ctrl_t ICC_CTRL_RST = icc_ctrl_t'(7'h00);

  typedef struct packed {
    logic full;
    logic empty;
  } icc_fifo_st_t;

  // Control word as software sees it, unimplemented bits zero
  function automatic logic [15:0] icc_ctrl_word(icc_ctrl_t c, logic ovf, logic bne);
    logic [15:0] w;
    w = 16'h0000;
    w[ICC_B_IDLE] = c.idle_halt;
    w[ICC_B_TSEL] = c.tsel;
    w[ICC_B_CPI +: 2] = c.cpi;
    w[ICC_B_OVF] = ovf;
    w[ICC_B_BNE] = bne;
    w[ICC_B_MODE +: 3] = c.mode;
    return w;
  endfunction
endpackage

// File: src/icc_fifo.sv
// Four-entry capture value FIFO
`timescale 1ns/1ps
module icc_fifo import icc_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic push,
  input wire logic [ICC_TW-1:0] wdata,
  input wire logic pop,
  output logic [ICC_TW-1:0] rdata,
  output icc_fifo_st_t st
);
  logic [ICC_TW-1:0] mem_ff [ICC_DEPTH];
  logic [ICC_PW-1:0] wp_ff;
  logic [ICC_PW-1:0] rp_ff;
  logic [ICC_PW:0] cnt_ff;
  wire do_push = push && !st.full;
  wire do_pop = pop && !st.empty;

  assign st.full = (cnt_ff == (ICC_PW+1)'(ICC_DEPTH));
  assign st.empty = (cnt_ff == (ICC_PW+1)'(0));
  assign rdata = mem_ff[rp_ff];

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_ff[wp_ff] <= wdata; // [R15]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (do_push) wp_ff <= wp_ff + ICC_PW'(1); // [R16]
      if (do_pop) rp_ff <= rp_ff + ICC_PW'(1); // [R16]
      cnt_ff <= cnt_ff + (ICC_PW+1)'(do_push) - (ICC_PW+1)'(do_pop);
    end
  end

  a_fifo_order: assert property (@(posedge clk) disable iff (!rst_n)
    st.empty && do_push |=> rdata == $past(wdata)) // [R16]
    else $error("fifo head is not the first value pushed");
endmodule // icc_fifo

// File: src/icc_edge.sv
// Pin synchroniser, edge detect and prescaler for capture events
`timescale 1ns/1ps
module icc_edge import icc_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  input wire logic [2:0] mode,
  input wire logic run,
  input wire logic lowpwr,
  input wire logic restart,
  output logic cap_evt,
  output logic wake_evt
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic [3:0] pre_ff;
  wire rise = s2_ff && !s3_ff;
  wire fall = !s2_ff && s3_ff;
  wire [3:0] pre_last = (mode == ICC_M_PRE16) ? ICC_PRE16_LAST : ICC_PRE4_LAST;
  wire pre_mode = (mode == ICC_M_PRE4) || (mode == ICC_M_PRE16);
  wire pre_hit = rise && (pre_ff == pre_last);
  logic qual;

  always_comb begin
    unique case (mode)
      ICC_M_EDGE: qual = rise || fall; // [R7]
      ICC_M_FALL: qual = fall; // [R9]
      ICC_M_RISE: qual = rise; // [R9]
      ICC_M_PRE4: qual = pre_hit; // [R10]
      ICC_M_PRE16: qual = pre_hit; // [R11]
      default: qual = 1'b0; // [R6] [R12] [R13]
    endcase
  end

  assign cap_evt = run && qual;
  assign wake_evt = (mode == ICC_M_WAKE) && lowpwr && rise; // [R13]

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      pre_ff <= 4'h0;
    end else begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (restart || !pre_mode) pre_ff <= 4'h0;
      else if (run && rise) pre_ff <= pre_hit ? 4'h0 : pre_ff + 4'h1; // [R10] [R11]
    end
  end

  a_pre_fourth: assert property (@(posedge clk) disable iff (!rst_n)
    cap_evt && mode == ICC_M_PRE4 |-> rise && pre_ff == ICC_PRE4_LAST) // [R10]
    else $error("divide-by-four capture off its count");
  a_pre_sixteen: assert property (@(posedge clk) disable iff (!rst_n)
    cap_evt && mode == ICC_M_PRE16 |-> rise && pre_ff == ICC_PRE16_LAST) // [R11]
    else $error("divide-by-sixteen capture off its count");
  a_edge_kind: assert property (@(posedge clk) disable iff (!rst_n)
    cap_evt |-> (mode == ICC_M_FALL) ? fall : rise || (mode == ICC_M_EDGE && fall)) // [R7] [R9]
    else $error("capture on the wrong edge");
  a_wake_only: assert property (@(posedge clk) disable iff (!rst_n)
    wake_evt |-> !cap_evt && lowpwr) // [R13]
    else $error("wake mode produced a capture");
endmodule // icc_edge

// File: verif/icc_pin_model.sv
// Model of the external signal on the capture input pin
`timescale 1ns/1ps
module icc_pin_model (
  input wire logic clk,
  output logic pin
);
  initial pin = 1'b0;
  // Level moves just after an edge; a hold of one cycle is still seen
  task automatic drive(input logic lvl, input int hold);
    @(posedge clk);
    pin <= lvl;
    repeat (hold) @(posedge clk);
  endtask
endmodule // icc_pin_model

// File: verif/testbench.sv
// Self-checking bench for the input capture channel
`timescale 1ns/1ps
module testbench import icc_pkg::*; ;
  logic clk;
  logic nrst;
  logic psel;
  logic penable;
  logic pwrite;
  logic pready;
  logic pslverr;
  logic cpu_idle;
  logic cpu_sleep;
  logic irq;
  wire pin;
  logic [ICC_AW-1:0] paddr;
  logic [ICC_DW-1:0] pwdata;
  logic [ICC_DW-1:0] prdata;
  logic [ICC_TW-1:0] t1;
  logic [ICC_TW-1:0] t2;
  logic [ICC_DW:0] exp_q[$];
  logic [ICC_TW-1:0] cap_q[$];
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  int prs = 0;
  int icnt = 0;
  logic halt;
  logic tsel;
  logic ovf;
  logic [1:0] cpi;
  logic [2:0] mode;
  logic [2:0] st;
  logic [2:0] en;

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  icc_top dut_u (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_input_pin(pin), .first_timer_count(t1), .second_timer_count(t2),
    .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .irq(irq));
  icc_pin_model pin_u (.clk(clk), .pin(pin));

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [ICC_DW:0] got, input logic [ICC_DW:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end

  // Read results are judged against the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      chk({pslverr, prdata}, exp_q.pop_front(), "read");
  end

  task automatic apb(input logic wr, input logic [ICC_AW-1:0] a, input logic [ICC_DW-1:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk('0, '1, "apb wait");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [ICC_AW-1:0] a, input logic [ICC_DW:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, '0);
  endtask

  function automatic logic [ICC_DW:0] cw(input logic ov, input logic bn);
    return {19'h0, halt, 5'h0, tsel, cpi, ov, bn, mode};
  endfunction

  // Garbage in read-only and unused bits must not stick
  task automatic set_ctl(input logic h, input logic ts, input logic [1:0] c, input logic [2:0] m);
    if (m != mode) prs = 0;
    if (m != mode || c != cpi) icnt = 0;
    {halt, tsel, cpi, mode} = {h, ts, c, m};
    apb(1'b1, ICC_OFF_CTRL, {18'h3ffff, h, 5'h1f, ts, c, 2'h3, m});
  endtask

  task automatic edge_ev(input logic rise);
    logic [ICC_TW-1:0] a;
    logic [ICC_TW-1:0] b;
    logic cap;
    a = 16'($urandom);
    b = 16'($urandom);
    cap = 1'b0;
    @(posedge clk);
    t1 <= a;
    t2 <= b;
    if (!cpu_sleep && !(cpu_idle && halt)) begin
      case (mode)
        ICC_M_EDGE: cap = 1'b1;
        ICC_M_RISE: cap = rise;
        ICC_M_FALL: cap = !rise;
        ICC_M_PRE4, ICC_M_PRE16: if (rise) begin
          prs++;
          cap = (prs == (mode == ICC_M_PRE4 ? 4 : 16));
          if (cap) prs = 0;
        end
        default: cap = 1'b0;
      endcase
    end
    if (mode == ICC_M_WAKE && rise && (cpu_idle || cpu_sleep)) st[ICC_I_WAKE] = 1'b1;
    if (cap && cap_q.size() == ICC_DEPTH) begin
      st[ICC_I_OVF] = 1'b1;
      ovf = 1'b1;
    end else if (cap) begin
      cap_q.push_back(tsel ? a : b);
      icnt++;
      if (icnt == (mode == ICC_M_EDGE ? 1 : cpi + 1)) begin
        st[ICC_I_CAP] = 1'b1;
        icnt = 0;
      end
    end
    pin_u.drive(rise, 6);
  endtask

  task automatic run(input logic h, input logic [1:0] c, input logic [2:0] m, input int n,
      input logic idl, input logic slp);
    en = 3'($urandom);
    apb(1'b1, ICC_OFF_EN, {29'h0, en});
    rd(ICC_OFF_EN, {30'h0, en});
    set_ctl(h, 1'($urandom), c, m);
    cpu_idle <= idl;
    cpu_sleep <= slp;
    @(posedge clk);
    repeat (n) begin
      edge_ev(1'b1);
      edge_ev(1'b0);
    end
    rd(ICC_OFF_STAT, {30'h0, st});
    rd(ICC_OFF_CTRL, cw(ovf, cap_q.size() > 0));
    chk({32'h0, irq}, {32'h0, |(st & en)}, "irq");
    while (cap_q.size() > 0) rd(ICC_OFF_BUF, {17'h0, cap_q.pop_front()});
    rd(ICC_OFF_BUF, '0);
    ovf = 1'b0;
    rd(ICC_OFF_CTRL, cw(1'b0, 1'b0));
    apb(1'b1, ICC_OFF_CLR, 32'h7);
    st = '0;
    rd(ICC_OFF_STAT, '0);
    cpu_idle <= 1'b0;
    cpu_sleep <= 1'b0;
  endtask

  initial begin
    {nrst, psel, penable, pwrite, cpu_idle, cpu_sleep, halt, tsel, ovf} = '0;
    {paddr, pwdata, t1, t2, cpi, mode, st, en} = '0;
    void'($urandom(97));
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rd(ICC_OFF_CTRL, '0);
    rd(ICC_OFF_STAT, '0);
    rd(ICC_OFF_EN, '0);
    rd(ICC_OFF_BUF, '0);
    rd(8'h14, {1'b1, 32'h0});
    set_ctl(1'b1, 1'b1, 2'h3, ICC_M_WAKE);
    rd(ICC_OFF_CTRL, cw(1'b0, 1'b0));
    for (int m = 0; m < 8; m++) run(1'b0, 2'h0, m[2:0], 2, 1'b0, 1'b0);
    run(1'b0, 2'h0, ICC_M_PRE4, 16, 1'b0, 1'b0);
    run(1'b0, 2'h0, ICC_M_PRE16, 17, 1'b0, 1'b0);
    run(1'b0, 2'h0, ICC_M_EDGE, 3, 1'b0, 1'b0);
    run(1'b0, 2'h3, ICC_M_EDGE, 1, 1'b0, 1'b0);
    for (int c = 0; c < 4; c++) begin
      run(1'b0, c[1:0], ICC_M_RISE, c, 1'b0, 1'b0);
      run(1'b0, c[1:0], ICC_M_RISE, 1, 1'b0, 1'b0);
    end
    run(1'b1, 2'h0, ICC_M_RISE, 1, 1'b1, 1'b0);
    run(1'b0, 2'h0, ICC_M_RISE, 1, 1'b1, 1'b0);
    run(1'b0, 2'h0, ICC_M_RISE, 1, 1'b0, 1'b1);
    run(1'b0, 2'h0, ICC_M_WAKE, 1, 1'b1, 1'b0);
    run(1'b1, 2'h2, ICC_M_WAKE, 1, 1'b0, 1'b1);
    tally_and_finish();
  end
endmodule // testbench
